// ==== core/ipc_cfg.svh ====
// Register offsets, field positions and reset values of the priority controller
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
`define IPC_OFS_PRIO_NVM_ADC_TX 5'h00
`define IPC_OFS_PRIO_CN_CMP_I2C 5'h01
`define IPC_OFS_PRIO_EXT_ONE 5'h02
`define IPC_OFS_PRIO_EXT_TWO 5'h03
`define IPC_OFS_PRIO_SER_ERR 5'h04
`define IPC_OFS_PRIO_VDET 5'h05
`define IPC_OFS_PRIO_CTMU 5'h06
`define IPC_OFS_CTRL_STATUS 5'h07
`define IPC_OFS_FLAG 5'h08
`define IPC_OFS_ENABLE 5'h09
`define IPC_OFS_CPU_CTRL 5'h0A
`define IPC_OFS_EVT_STATUS 5'h0B
`define IPC_OFS_EVT_CLEAR 5'h0C
`define IPC_OFS_EVT_ENABLE 5'h0D
`define IPC_PRIO_RESET 3'h4
`define IPC_BIT_REQ_UNACKED 15
`define IPC_BIT_VEC_HOLD 13
`define IPC_BIT_NEST_DIS 15
`define IPC_USER_MAX 4'h7
`define IPC_VEC_BASE 8
`endif

// ==== core/ipc_pkg.sv ====
// Types shared by the priority controller
package ipc_pkg;
    typedef enum logic [1:0] {
        IPC_IDLE,
        IPC_SERVE
    } ipc_state_t;
    typedef logic [2:0] ipc_prio_t;
endpackage

// ==== core/ipc_ctrl.sv ====
// Interrupt priority and vectoring controller with a register port
//
// Overview of operation
// - Three-bit priority per source; seven highest, one lowest.
// - Priority zero never raises a processor request.
// - Reset sets every source priority to four.
// - Unimplemented bits ignore writes and read zero.
// - Request-pending status bit high while a request waits unacknowledged.
// - Vector hold one: vector field shows highest pending source.
// - Vector hold zero: vector field shows last acknowledged source.
// - Acknowledge only when priority exceeds current processor level.
// - Four-bit field shows new processor priority level.
// - Seven-bit vector field equals vector number minus eight.
// - Return restores previous processor priority level.
// - Level seven masks user sources; traps at eight to fifteen never masked (here a trap is held while the processor level is at or above its level).
// - Timed disable blocks levels one to six, level seven passes.
// - Nesting disable stops pre-emption of a routine in progress.
// - Flag set by request; enable must be set to pass it.
//
// Decided for this implementation: the plain strobed port and the address map.
`include "ipc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ipc_ctrl
    import ipc_pkg::*;
#(
    parameter int NSRC = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // Peripheral request pulses, one per source
    input wire logic [NSRC-1:0] src_req,
    // Processor side
    input wire logic [6:0] src_vec [NSRC],
    input wire logic [3:0] cpu_level,
    input wire logic cpu_ack,
    input wire logic cpu_return,
    input wire logic timed_disable,
    input wire logic trap_req,
    input wire logic [2:0] trap_level,
    output logic cpu_irq,
    output logic [6:0] cpu_vector,
    output logic [3:0] cpu_new_level,
    // Event interrupt
    output logic evt_irq
);
    // Registered state
    ipc_prio_t prio_reg [NSRC];
    ipc_prio_t prio_next [NSRC];
    logic [NSRC-1:0] flag_reg, flag_next, en_reg, en_next;
    logic vector_hold_reg, vector_hold_next, nest_dis_reg, nest_dis_next;
    logic [6:0] last_vec_reg, last_vec_next;
    logic [3:0] saved_level_reg, saved_level_next;
    logic [3:0] new_level_reg, new_level_next;
    logic [1:0] evt_reg, evt_next, evt_en_reg, evt_en_next;
    logic [15:0] rdata_reg, rdata_next;
    ipc_state_t state_reg, state_next;
    // Arbitration
    logic win_valid;
    logic [3:0] win_level;
    logic [6:0] win_vec;
    logic [3:0] threshold;
    logic req_unacked;
    logic ack_fire;
    logic [15:0] field_word [7];

    // Source index mapping: per register, the source in each of the four slots
    function automatic int slot_src(input int r, input int s);
        int m;
        m = -1;
        case (r)
            0: m = (s == 3) ? 0 : (s == 1) ? 1 : (s == 0) ? 2 : -1;
            1: m = s + 3;
            2: m = (s == 0) ? 7 : -1;
            3: m = (s == 1) ? 8 : -1;
            4: m = (s == 1) ? 9 : -1;
            5: m = (s == 0) ? 10 : -1;
            6: m = (s == 1) ? 11 : -1;
            default: m = -1;
        endcase
        return m;
    endfunction

    // Highest eligible source; strict compare keeps the lowest vector on ties
    always_comb begin
        win_valid = 1'b0;
        win_level = 4'h0;
        win_vec = 7'h00;
        for (int i = 0; i < NSRC; i++) begin
            if (flag_reg[i] && en_reg[i] && prio_reg[i] != 3'h0) begin
                if (!win_valid || {1'b0, prio_reg[i]} > win_level ||
                    ({1'b0, prio_reg[i]} == win_level && src_vec[i] < win_vec)) begin
                    win_valid = 1'b1;
                    win_level = {1'b0, prio_reg[i]};
                    win_vec = src_vec[i];
                end
            end
        end
        if (trap_req) begin
            win_valid = 1'b1;
            win_level = {1'b1, trap_level};
            win_vec = 7'h00;
        end
    end

    // Effective masking level: timed disable lifts the floor to six
    always_comb begin
        threshold = cpu_level;
        if (timed_disable && threshold < 4'h6) begin
            threshold = 4'h6;
        end
        if (state_reg == IPC_SERVE && nest_dis_reg && !trap_req) begin
            threshold = `IPC_USER_MAX;
        end
    end

    assign req_unacked = win_valid && (win_level > threshold);
    assign ack_fire = req_unacked && cpu_ack;

    // Register readback words, unimplemented bits zero
    always_comb begin
        int k;
        k = 0;
        for (int r = 0; r < 7; r++) begin
            field_word[r] = 16'h0000;
            for (int s = 0; s < 4; s++) begin
                k = slot_src(r, s);
                if (k >= 0 && k < NSRC) begin
                    field_word[r][s*4 +: 3] = prio_reg[k];
                end
            end
        end
    end

    // Next state of registers
    always_comb begin
        int k;
        k = 0;
        prio_next = prio_reg;
        flag_next = flag_reg;
        en_next = en_reg;
        vector_hold_next = vector_hold_reg;
        nest_dis_next = nest_dis_reg;
        last_vec_next = last_vec_reg;
        saved_level_next = saved_level_reg;
        new_level_next = new_level_reg;
        evt_next = evt_reg;
        evt_en_next = evt_en_reg;
        rdata_next = 16'h0000;
        state_next = state_reg;
        if (reg_wr) begin
            if (reg_addr < 5'h07) begin
                for (int s = 0; s < 4; s++) begin
                    k = slot_src(int'(reg_addr), s);
                    if (k >= 0 && k < NSRC) begin
                        prio_next[k] = reg_wdata[s*4 +: 3];
                    end
                end
            end
            case (reg_addr)
                `IPC_OFS_CTRL_STATUS: vector_hold_next = reg_wdata[`IPC_BIT_VEC_HOLD];
                `IPC_OFS_FLAG: flag_next = reg_wdata[NSRC-1:0];
                `IPC_OFS_ENABLE: en_next = reg_wdata[NSRC-1:0];
                `IPC_OFS_CPU_CTRL: nest_dis_next = reg_wdata[`IPC_BIT_NEST_DIS];
                `IPC_OFS_EVT_CLEAR: evt_next = evt_reg & ~reg_wdata[1:0];
                `IPC_OFS_EVT_ENABLE: evt_en_next = reg_wdata[1:0];
                default: ;
            endcase
        end
        // Hardware set wins over a software clear in the same cycle
        flag_next = flag_next | src_req;
        // Acknowledge: capture vector, raise level, remember old level
        if (ack_fire) begin
            last_vec_next = win_vec - 7'(`IPC_VEC_BASE);
            saved_level_next = cpu_level;
            new_level_next = win_level;
            state_next = IPC_SERVE;
            evt_next[0] = 1'b1;
        end else if (cpu_return) begin
            new_level_next = saved_level_reg;
            state_next = IPC_IDLE;
            evt_next[1] = 1'b1;
        end
        if (reg_rd) begin
            case (reg_addr)
                `IPC_OFS_CTRL_STATUS: begin
                    rdata_next[`IPC_BIT_REQ_UNACKED] = req_unacked;
                    rdata_next[`IPC_BIT_VEC_HOLD] = vector_hold_reg;
                    rdata_next[11:8] = new_level_reg;
                    rdata_next[6:0] = cpu_vector;
                end
                `IPC_OFS_FLAG: rdata_next[NSRC-1:0] = flag_reg;
                `IPC_OFS_ENABLE: rdata_next[NSRC-1:0] = en_reg;
                `IPC_OFS_CPU_CTRL: rdata_next[`IPC_BIT_NEST_DIS] = nest_dis_reg;
                `IPC_OFS_EVT_STATUS: rdata_next[1:0] = evt_reg;
                `IPC_OFS_EVT_ENABLE: rdata_next[1:0] = evt_en_reg;
                default: begin
                    if (reg_addr < 5'h07) begin
                        rdata_next = field_word[reg_addr[2:0]];
                    end
                end
            endcase
        end
    end

    // Register all state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < NSRC; i++) begin
                prio_reg[i] <= `IPC_PRIO_RESET;
            end
            flag_reg <= '0;
            en_reg <= '0;
            vector_hold_reg <= 1'b0;
            nest_dis_reg <= 1'b0;
            last_vec_reg <= 7'h00;
            saved_level_reg <= 4'h0;
            new_level_reg <= 4'h0;
            evt_reg <= 2'h0;
            evt_en_reg <= 2'h0;
            rdata_reg <= 16'h0000;
            state_reg <= IPC_IDLE;
        end else begin
            prio_reg <= prio_next;
            flag_reg <= flag_next;
            en_reg <= en_next;
            vector_hold_reg <= vector_hold_next;
            nest_dis_reg <= nest_dis_next;
            last_vec_reg <= last_vec_next;
            saved_level_reg <= saved_level_next;
            new_level_reg <= new_level_next;
            evt_reg <= evt_next;
            evt_en_reg <= evt_en_next;
            rdata_reg <= rdata_next;
            state_reg <= state_next;
        end
    end

    // Outputs; vector view chosen by the hold bit
    assign cpu_vector = vector_hold_reg ? (win_vec - 7'(`IPC_VEC_BASE)) : last_vec_reg;
    assign cpu_irq = req_unacked;
    assign cpu_new_level = new_level_reg;
    assign reg_rdata = rdata_reg;
    assign evt_irq = |(evt_reg & evt_en_reg);

    // Zero priority keeps a lone source silent
    prio_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!trap_req && ((flag_reg & en_reg) == (NSRC)'(1)) && prio_reg[0] == 3'h0)
        |-> !cpu_irq) else $error("zero priority raised request");
    reset_prio_a: assert property (@(posedge clk) $fell(sys_rst) |-> prio_reg[0] == 3'h4)
        else $error("priority not four after reset");
    ack_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        ack_fire |=> cpu_new_level == $past(win_level))
        else $error("level not raised on acknowledge");
    ack_only_above_a: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_irq |-> win_level > cpu_level) else $error("request not above level");
    return_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_return && !ack_fire) |=> cpu_new_level == $past(saved_level_reg))
        else $error("level not restored");
    mask_seven_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_level == 4'h7 && !trap_req) |-> !cpu_irq)
        else $error("user request at level seven");
    timed_dis_a: assert property (@(posedge clk) disable iff (sys_rst)
        (timed_disable && cpu_irq) |-> win_level >= 4'h7)
        else $error("low level passed timed disable");
    hold_view_a: assert property (@(posedge clk) disable iff (sys_rst)
        (!vector_hold_reg && !$past(vector_hold_reg) && !$past(ack_fire)) |-> $stable(cpu_vector))
        else $error("vector moved without acknowledge");
    flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
        src_req[0] |=> flag_reg[0]) else $error("request lost");

    // A trap outranks any user level the processor can hold
    trap_pass_a: assert property (@(posedge clk) disable iff (sys_rst)
        (trap_req && cpu_level < 4'h8)
        |-> cpu_irq)
        else $error("trap request masked");
    // A raised request always has an eligible source behind it
    irq_source_a: assert property (@(posedge clk) disable iff (sys_rst)
        cpu_irq
        |-> win_valid)
        else $error("request without source");
    // Status readback carries the pending bit of the read cycle
    pend_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == `IPC_OFS_CTRL_STATUS)
        |=> reg_rdata[`IPC_BIT_REQ_UNACKED] == $past(req_unacked))
        else $error("pending bit misread");
    // Hold bit reads back as written
    hold_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == `IPC_OFS_CTRL_STATUS)
        |=> reg_rdata[`IPC_BIT_VEC_HOLD] == $past(vector_hold_reg))
        else $error("hold bit misread");
    // Level field reads the registered new level
    level_read_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == `IPC_OFS_CTRL_STATUS)
        |=> reg_rdata[11:8] == $past(new_level_reg))
        else $error("level field misread");
    // Unused status bits stay zero
    status_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr == `IPC_OFS_CTRL_STATUS)
        |=> !reg_rdata[14] && !reg_rdata[12] && !reg_rdata[7])
        else $error("unused status bit set");
    // Top bit of every priority nibble reads zero
    prio_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_rd && reg_addr < 5'h07)
        |=> (reg_rdata & 16'h8888) == 16'h0000)
        else $error("unused priority bit set");
    // Read data is zero outside the answer cycle
    rdata_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        !reg_rd
        |=> reg_rdata == 16'h0000)
        else $error("read data outside answer cycle");
    // Live view is the winner's vector less the base
    vec_offset_a: assert property (@(posedge clk) disable iff (sys_rst)
        (vector_hold_reg && win_valid && !trap_req)
        |-> 7'(cpu_vector + 7'(`IPC_VEC_BASE)) == win_vec)
        else $error("vector field offset wrong");
    // While serving with nesting off, no user source may pre-empt
    nest_block_a: assert property (@(posedge clk) disable iff (sys_rst)
        (state_reg == IPC_SERVE && nest_dis_reg && !trap_req)
        |-> !cpu_irq)
        else $error("pre-emption with nesting off");
    // A return ends the service state
    return_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_return && !ack_fire)
        |=> state_reg == IPC_IDLE)
        else $error("service state kept after return");
    // Every acknowledge is logged as an event
    ack_event_a: assert property (@(posedge clk) disable iff (sys_rst)
        ack_fire
        |=> evt_reg[0])
        else $error("acknowledge event lost");
    // First slot of the third priority register lands from the low write bits
    wr_prio_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == `IPC_OFS_PRIO_EXT_ONE)
        |=> prio_reg[7] == 3'($past(reg_wdata)))
        else $error("priority write lost");
    // At level zero any eligible source is offered
    ack_open_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cpu_level == 4'h0 && !timed_disable && state_reg == IPC_IDLE && win_valid)
        |-> cpu_irq)
        else $error("eligible request held back");
    // Software clear cannot drop a request arriving in the same cycle
    set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
        (reg_wr && reg_addr == `IPC_OFS_FLAG && src_req[0])
        |=> flag_reg[0])
        else $error("clear beat request");
    // Acknowledged vector is captured as field value
    ack_vector_a: assert property (@(posedge clk) disable iff (sys_rst)
        (ack_fire && !trap_req)
        |=> 7'(last_vec_reg + 7'(`IPC_VEC_BASE)) == $past(win_vec))
        else $error("acknowledged vector lost");
    // A winner never sits at level zero
    no_zero_win_a: assert property (@(posedge clk) disable iff (sys_rst)
        win_valid
        |-> win_level != 4'h0)
        else $error("zero level winner");
    // User winners stay within seven
    user_cap_a: assert property (@(posedge clk) disable iff (sys_rst)
        (win_valid && !trap_req)
        |-> win_level <= `IPC_USER_MAX)
        else $error("user level above seven");
    // Traps always sit at eight or above
    trap_level_a: assert property (@(posedge clk) disable iff (sys_rst)
        trap_req
        |-> win_level >= 4'h8)
        else $error("trap below eight");
    // Timed disable still lets level seven through
    keep_seven_a: assert property (@(posedge clk) disable iff (sys_rst)
        (timed_disable && cpu_level < 4'h7 && state_reg == IPC_IDLE && win_level == 4'h7)
        |-> cpu_irq)
        else $error("level seven blocked by timed disable");
endmodule
`default_nettype wire

// ==== sim/ipc_core_model.sv ====
// Processor core model that takes requests and returns from them
`timescale 1ns/1ps
`default_nettype none
module ipc_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Bench controls
    input wire logic take_en,
    input wire logic ret_go,
    // Controller side
    input wire logic cpu_irq,
    output logic cpu_ack,
    output logic cpu_return
);
    logic taken;
    // One acknowledge per take, only while a request is raised
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_ack <= 1'b0;
            cpu_return <= 1'b0;
            taken <= 1'b0;
        end else begin
            cpu_ack <= take_en && cpu_irq && !taken && !cpu_ack;
            taken <= take_en && (taken || cpu_ack);
            cpu_return <= ret_go;
        end
    end
endmodule
`default_nettype wire

// ==== sim/ipc_ctrl_test.sv ====
// Self-checking bench for the interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module ipc_ctrl_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic [11:0] src_req = 12'h000;
    logic [6:0] vec [12];
    logic [3:0] cpu_level = 4'h0;
    logic tdis = 1'b0;
    logic trap = 1'b0;
    logic [2:0] tlev = 3'h0;
    logic take_en = 1'b0;
    logic ret_go = 1'b0;
    logic ack, ret, irq, evt;
    logic [6:0] cvec;
    logic [3:0] nlev;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    // Implemented priority bits, in offset order
    logic [15:0] mask [7] = '{16'h7077, 16'h7777, 16'h0007, 16'h0070,
        16'h0070, 16'h0007, 16'h0070};
    always #5 clk = ~clk;
    initial for (int i = 0; i < 12; i++) vec[i] = 7'(20 + i);
    ipc_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .src_req(src_req), .src_vec(vec),
        .cpu_level(cpu_level), .cpu_ack(ack), .cpu_return(ret),
        .timed_disable(tdis), .trap_req(trap), .trap_level(tlev),
        .cpu_irq(irq), .cpu_vector(cvec), .cpu_new_level(nlev),
        .evt_irq(evt));
    ipc_core_model CPU (.clk(clk), .sys_rst(sys_rst), .take_en(take_en),
        .ret_go(ret_go), .cpu_irq(irq), .cpu_ack(ack), .cpu_return(ret));
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(logic [4:0] a, logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [4:0] a, logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", exp, reg_rdata);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, far above the roughly 130 cycles the run needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        // Priority registers: reset level four, unused bits stay zero
        for (int i = 0; i < 7; i++) rd(5'(i), mask[i] & 16'h4444);
        for (int i = 0; i < 7; i++) wr(5'(i), 16'hFFFF);
        for (int i = 0; i < 7; i++) rd(5'(i), mask[i]);
        wr(5'h1F, 16'hFFFF);
        rd(5'h1F, 16'h0000);
        $display("test registers done");
        // Three sources pending, the highest eligible one presented
        wr(5'h00, 16'h0035);
        wr(5'h08, 16'h0000);
        wr(5'h09, 16'h0007);
        @(posedge clk);
        src_req <= 12'h007;
        @(posedge clk);
        src_req <= 12'h000;
        tick(2);
        chk("irq", 16'h1, 16'(irq));
        rd(5'h07, 16'h8000);
        wr(5'h07, 16'h2000);
        rd(5'h07, 16'hA00E);
        take_en <= 1'b1;
        tick(4);
        chk("level", 16'h5, 16'(nlev));
        cpu_level <= 4'h5;
        take_en <= 1'b0;
        wr(5'h08, 16'h0002);
        wr(5'h07, 16'h0000);
        tick(2);
        chk("irq", 16'h0, 16'(irq));
        chk("vector", 16'd14, 16'(cvec));
        wr(5'h07, 16'h2000);
        tick(1);
        chk("vector", 16'd13, 16'(cvec));
        ret_go <= 1'b1;
        tick(1);
        ret_go <= 1'b0;
        tick(3);
        chk("level", 16'h0, 16'(nlev));
        $display("test vectoring done");
        // Event interrupt: raise, mask, clear
        rd(5'h0B, 16'h0003);
        chk("evt", 16'h0, 16'(evt));
        wr(5'h0D, 16'h0002);
        tick(1);
        chk("evt", 16'h1, 16'(evt));
        wr(5'h0C, 16'h0003);
        tick(1);
        chk("evt", 16'h0, 16'(evt));
        rd(5'h0B, 16'h0000);
        $display("test events done");
        // Level seven masks users, traps still pass
        cpu_level <= 4'h7;
        wr(5'h00, 16'h0070);
        tick(2);
        chk("irq", 16'h0, 16'(irq));
        trap <= 1'b1;
        tlev <= 3'h7;
        tick(2);
        chk("irq", 16'h1, 16'(irq));
        trap <= 1'b0;
        cpu_level <= 4'h0;
        tdis <= 1'b1;
        tick(2);
        chk("irq", 16'h1, 16'(irq));
        wr(5'h00, 16'h0060);
        tick(2);
        chk("irq", 16'h0, 16'(irq));
        tdis <= 1'b0;
        tick(2);
        chk("irq", 16'h1, 16'(irq));
        wr(5'h00, 16'h0000);
        tick(2);
        chk("irq", 16'h0, 16'(irq));
        $display("test masking done");
        // Nesting disable holds off a higher request while serving
        wr(5'h0A, 16'h8000);
        wr(5'h00, 16'h0010);
        tick(2);
        chk("irq", 16'h1, 16'(irq));
        take_en <= 1'b1;
        tick(4);
        take_en <= 1'b0;
        chk("level", 16'h1, 16'(nlev));
        wr(5'h00, 16'h0050);
        tick(2);
        chk("irq", 16'h0, 16'(irq));
        ret_go <= 1'b1;
        tick(1);
        ret_go <= 1'b0;
        tick(3);
        chk("irq", 16'h1, 16'(irq));
        rd(5'h0A, 16'h8000);
        $display("test nesting done");
        conclude();
    end
endmodule
`default_nettype wire
